//--- hdl/pfbdz_cfg.svh
`ifndef PFBDZ_CFG_SVH
`define PFBDZ_CFG_SVH

// register byte offsets inside the pwm unit
`define PFBDZ_OFF_CTRL      8'h60
`define PFBDZ_OFF_DZ        8'h64
`define PFBDZ_OFF_STAT      8'h70
`define PFBDZ_OFF_MASK      8'h74

// reset values
`define PFBDZ_CTRL_RST      32'h0000_0000
`define PFBDZ_DZ_RST        32'h0000_0000
`define PFBDZ_STAT_RST      32'h0000_0000
`define PFBDZ_MASK_RST      32'h0000_0000

// writable bits of each register
`define PFBDZ_CTRL_RW_MASK  32'hff00_000f
`define PFBDZ_DZ_RW_MASK    32'h00ff_ffff
`define PFBDZ_STAT_W1C_MASK 32'h0000_0007

// fault brake control fields
`define PFBDZ_BIT_EN0       0
`define PFBDZ_BIT_EN1       1
`define PFBDZ_BIT_SEL1      2
`define PFBDZ_BIT_SEL0      3
`define PFBDZ_BIT_EVENT     7
`define PFBDZ_LVL_LSB       24
`define PFBDZ_BIT_AUX_A     30
`define PFBDZ_BIT_AUX_B     31

// dead-zone length field width
`define PFBDZ_LEN_W         8

// interrupt status fields
`define PFBDZ_STAT_IN0      0
`define PFBDZ_STAT_IN1      1
`define PFBDZ_STAT_ENTRY    2
`define PFBDZ_STAT_ACTIVE   8

`endif

//--- hdl/pfbdz_pkg.sv
package pfbdz_pkg;

    // brake state of the output stage
    typedef enum logic [0:0] {
        PFBDZ_RUN   = 1'b0,
        PFBDZ_BRAKE = 1'b1
    } pfbdz_brk_t;

    // one apb data word
    typedef logic [31:0] pfbdz_word_t;

    // dead-zone length in time units
    typedef logic [7:0] pfbdz_len_t;

    // register byte offset
    typedef logic [7:0] pfbdz_addr_t;

endpackage

//--- hdl/pfbdz_pair_if.sv
`timescale 1ns/10ps

// one complementary channel pair between the brake logic and its dead-zone stage
interface pfbdz_pair_if;
    logic               raw_even;  // even channel from the counters
    logic               raw_odd;   // odd channel from the counters
    logic               dz_en;     // dead-zone insertion enabled
    logic               tick;      // one time unit of this pair
    pfbdz_pkg::pfbdz_len_t len;    // dead-zone length
    logic               out_even;  // even channel after dead zone
    logic               out_odd;   // odd channel after dead zone

    modport ctl (output raw_even, raw_odd, dz_en, tick, len, input out_even, out_odd);
    modport dz  (input raw_even, raw_odd, dz_en, tick, len, output out_even, out_odd);
endinterface

//--- hdl/pfbdz_deadzone.sv
`timescale 1ns/10ps

// dead-zone stage for one complementary pair
module pfbdz_deadzone (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // pair signals
    pfbdz_pair_if.dz  pair
);
    import pfbdz_pkg::*;

    logic       lvl_q, lvl_d;      // settled level of the even channel
    pfbdz_len_t cnt_q, cnt_d;      // remaining dead-zone units
    logic       even_q, even_d;    // even output
    logic       odd_q, odd_d;      // odd output

    // next state: hold both low for len units after each change
    always_comb begin
        lvl_d  = lvl_q;
        cnt_d  = cnt_q;
        even_d = even_q;
        odd_d  = odd_q;
        if (!pair.dz_en) begin
            // no dead zone: pass both channels straight
            lvl_d  = pair.raw_even;
            cnt_d  = '0;
            even_d = pair.raw_even;
            odd_d  = pair.raw_odd;
        end else if (pair.raw_even != lvl_q) begin
            // edge seen: start the gap, both outputs low for a nonzero len
            lvl_d  = pair.raw_even;
            cnt_d  = pair.len;                              // [R10]
            even_d = (pair.len == '0) ? pair.raw_even : 1'b0;  // [R15]
            odd_d  = (pair.len == '0) ? ~pair.raw_even : 1'b0;
        end else if (cnt_q != '0) begin
            // count time units of this pair's clock select
            if (pair.tick) begin
                cnt_d = cnt_q - 8'h01;                      // [R11]
            end
            even_d = 1'b0;                                  // [R15]
            odd_d  = 1'b0;
        end else begin
            // gap over: rising edge released
            even_d = lvl_q;
            odd_d  = ~lvl_q;
        end
    end

    // registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            lvl_q  <= 1'b0;
            cnt_q  <= '0;
            even_q <= 1'b0;
            odd_q  <= 1'b0;
        end else begin
            lvl_q  <= lvl_d;
            cnt_q  <= cnt_d;
            even_q <= even_d;
            odd_q  <= odd_d;
        end
    end

    assign pair.out_even = even_q;
    assign pair.out_odd  = odd_q;
endmodule

//--- hdl/pfbdz_top.sv
//
// Overview of operation
// [R1] brake forces six channels to level bits
// [R2] brake forces two aux outputs to levels
// [R3] event flag set on entering brake
// [R4] writing one clears event flag
// [R5] software clears flag before counter restart
// [R6] select feeds input zero: irq0 or comp1
// [R7] select feeds input one: irq1 or comp0
// [R8] enable one lets input one falls brake
// [R9] enable zero lets input zero falls brake
// [R10] three eight-bit dead-zone lengths, one per pair
// [R11] dead-zone unit from pair clock select
// [R12] both registers reset to zero
// [R13] per-input falling flags, write one clears
// [R14] brake holds until flag cleared and restart
// [R15] dead zone delays rising edges of pair
//
`timescale 1ns/10ps
`include "pfbdz_cfg.svh"

module pfbdz_top (
    // clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    // apb slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire pfbdz_pkg::pfbdz_addr_t paddr_i,
    input  wire pfbdz_pkg::pfbdz_word_t pwdata_i,
    output pfbdz_pkg::pfbdz_word_t    prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // brake source pins
    input  wire logic                 ext_irq_in_zero_i,
    input  wire logic                 ext_irq_in_one_i,
    input  wire logic                 comparator_out_zero_i,
    input  wire logic                 comparator_out_one_i,
    // rest of the pwm unit
    input  wire logic [5:0]           pwm_raw_i,
    input  wire logic [2:0]           pair_dz_en_i,
    input  wire logic [2:0]           pwm_clock_select_tick_i,
    input  wire logic                 counter_restart_i,
    input  wire logic [1:0]           aux_norm_i,
    // outputs to the power stage
    output logic [5:0]                pwm_o,
    output logic                      aux_out_a_o,
    output logic                      aux_out_b_o,
    output logic                      brake_o,
    output logic                      irq_o
);
    import pfbdz_pkg::*;

    // register file
    pfbdz_word_t ctrl_q, ctrl_d;       // fault_brake_control
    pfbdz_word_t dz_q, dz_d;           // dead_zone_interval
    pfbdz_word_t stat_q, stat_d;       // interrupt status
    pfbdz_word_t mask_q, mask_d;       // interrupt mask
    // apb answer
    pfbdz_word_t prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    // pin synchronisers: ext0, ext1, cmp0, cmp1
    logic [3:0]  sync1_q, sync1_d;
    logic [3:0]  sync2_q, sync2_d;
    logic [1:0]  prev_q, prev_d;       // last selected brake inputs
    // brake state and outputs
    pfbdz_brk_t  brk_q, brk_d;
    logic [5:0]  pwm_q, pwm_d;
    logic        aux_a_q, aux_a_d;
    logic        aux_b_q, aux_b_d;
    logic        irq_q, irq_d;

    // decoded strobes
    logic        setup;                // apb setup cycle
    logic        wr;                   // write takes effect
    logic [1:0]  brk_in;               // selected brake inputs
    logic [1:0]  fall;                 // falling edge per input
    logic [1:0]  trig;                 // enabled falling edges
    logic        trig_any;             // brake condition
    logic [5:0]  dz_out;               // channels after dead zone

    // true for an offset that this block answers
    function automatic logic addr_hit(input pfbdz_addr_t a);
        addr_hit = (a == `PFBDZ_OFF_CTRL) || (a == `PFBDZ_OFF_DZ) ||
                   (a == `PFBDZ_OFF_STAT) || (a == `PFBDZ_OFF_MASK);
    endfunction

    // write one to clear, with a hardware set winning over the clear
    function automatic pfbdz_word_t w1c(input pfbdz_word_t cur, input logic clr_en,
                                        input pfbdz_word_t clr, input pfbdz_word_t set);
        w1c = ((clr_en ? (cur & ~clr) : cur)) | set;
    endfunction

    // write strobe for one register offset, shared by every writable register
    function automatic logic wr_at(input logic w, input pfbdz_addr_t a,
                                   input pfbdz_addr_t off);
        wr_at = w && (a == off);
    endfunction

    // dead-zone stages, one per pair
    pfbdz_pair_if pair_if [3] ();

    for (genvar p = 0; p < 3; p++) begin : g_pair
        assign pair_if[p].raw_even = pwm_raw_i[2*p];
        assign pair_if[p].raw_odd  = pwm_raw_i[2*p+1];
        assign pair_if[p].dz_en    = pair_dz_en_i[p];
        assign pair_if[p].tick     = pwm_clock_select_tick_i[p];   // [R11]
        assign pair_if[p].len      = dz_q[8*p +: 8];               // [R10]
        assign dz_out[2*p]         = pair_if[p].out_even;
        assign dz_out[2*p+1]       = pair_if[p].out_odd;

        pfbdz_deadzone u_dz (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .pair   (pair_if[p])
        );
    end

    // apb phase decode: pready rises in the first access cycle
    assign setup = psel_i && !penable_i;
    assign wr    = psel_i && penable_i && pready_q && pwrite_i;

    // source selection and falling-edge detection on synchronised pins
    always_comb begin
        brk_in[0] = ctrl_q[`PFBDZ_BIT_SEL0] ? sync2_q[3] : sync2_q[0];   // [R6]
        brk_in[1] = ctrl_q[`PFBDZ_BIT_SEL1] ? sync2_q[2] : sync2_q[1];   // [R7]
        // a falling edge is a one last cycle and a zero now
        fall      = prev_q & ~brk_in;
        trig[0]   = fall[0] && ctrl_q[`PFBDZ_BIT_EN0];                  // [R9]
        trig[1]   = fall[1] && ctrl_q[`PFBDZ_BIT_EN1];                  // [R8]
        trig_any  = |trig;                                              // [R14]
    end

    // synchroniser next values
    always_comb begin
        // first stage samples the raw pins
        sync1_d = {comparator_out_one_i, comparator_out_zero_i,
                   ext_irq_in_one_i, ext_irq_in_zero_i};
        // second stage reads only the first
        sync2_d = sync1_q;
        // edge history of the selected inputs
        prev_d  = brk_in;
    end

    // synchroniser registers; pins idle high so edges start from one
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
            prev_q  <= 2'h3;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    // register file next values
    always_comb begin
        ctrl_d = ctrl_q;
        dz_d   = dz_q;
        mask_d = mask_q;
        // control: plain fields, event flag cleared by a one
        if (wr_at(wr, paddr_i, `PFBDZ_OFF_CTRL)) begin
            ctrl_d = (pwdata_i & `PFBDZ_CTRL_RW_MASK) |
                     (ctrl_q & ~`PFBDZ_CTRL_RW_MASK);
            if (pwdata_i[`PFBDZ_BIT_EVENT]) begin
                ctrl_d[`PFBDZ_BIT_EVENT] = 1'b0;                        // [R4]
            end
        end
        // hardware set comes last, so it wins over a same-cycle clear
        if (trig_any) begin
            ctrl_d[`PFBDZ_BIT_EVENT] = 1'b1;                            // [R3]
        end
        // dead-zone lengths, reserved top byte kept zero
        if (wr_at(wr, paddr_i, `PFBDZ_OFF_DZ)) begin
            dz_d = pwdata_i & `PFBDZ_DZ_RW_MASK;                        // [R10]
        end
        // interrupt mask, same layout as the status flags
        if (wr_at(wr, paddr_i, `PFBDZ_OFF_MASK)) begin
            mask_d = pwdata_i & `PFBDZ_STAT_W1C_MASK;
        end
        // per-input flags and brake entry, sticky until a one is written
        stat_d = w1c(stat_q, wr_at(wr, paddr_i, `PFBDZ_OFF_STAT),
                     pwdata_i & `PFBDZ_STAT_W1C_MASK,
                     {29'h0, trig_any, fall});                          // [R13]
    end

    // register file flip-flops, all cleared by reset
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl_q <= `PFBDZ_CTRL_RST;                                  // [R12]
            dz_q   <= `PFBDZ_DZ_RST;                                    // [R12]
            stat_q <= `PFBDZ_STAT_RST;
            mask_q <= `PFBDZ_MASK_RST;
        end else begin
            ctrl_q <= ctrl_d;
            dz_q   <= dz_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // apb answer: read data and error prepared in the setup cycle
    always_comb begin
        pready_d  = setup;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        if (setup) begin
            // error for an offset that no register answers
            pslverr_d = !addr_hit(paddr_i);
            // writes, reserved bits and unmapped offsets read as zero
            prdata_d  = '0;
            if (!pwrite_i) begin
                unique case (paddr_i)
                    `PFBDZ_OFF_CTRL: prdata_d = ctrl_q;
                    `PFBDZ_OFF_DZ:   prdata_d = dz_q;
                    `PFBDZ_OFF_STAT: begin
                        prdata_d = stat_q;
                        // live brake state beside the sticky flags
                        prdata_d[`PFBDZ_STAT_ACTIVE] = (brk_q == PFBDZ_BRAKE);
                    end
                    `PFBDZ_OFF_MASK: prdata_d = mask_q;
                    default:         prdata_d = '0;
                endcase
            end
        end
    end

    // apb answer registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // brake state machine and output stage
    always_comb begin
        brk_d = brk_q;
        unique case (brk_q)
            PFBDZ_RUN: begin
                if (trig_any) begin
                    brk_d = PFBDZ_BRAKE;                                // [R14]
                end
            end
            PFBDZ_BRAKE: begin
                // leave only once the flag is clear and counters restart
                if (!ctrl_q[`PFBDZ_BIT_EVENT] && counter_restart_i && !trig_any) begin
                    brk_d = PFBDZ_RUN;                                  // [R14] [R5]
                end
            end
        endcase
        // forced levels follow the control bits live while braked
        if (brk_d == PFBDZ_BRAKE) begin
            pwm_d   = ctrl_q[`PFBDZ_LVL_LSB +: 6];                      // [R1]
            aux_a_d = ctrl_q[`PFBDZ_BIT_AUX_A];                         // [R2]
            aux_b_d = ctrl_q[`PFBDZ_BIT_AUX_B];                         // [R2]
        end else begin
            // normal run: dead-zone outputs and aux pass-through
            pwm_d   = dz_out;
            aux_a_d = aux_norm_i[0];
            aux_b_d = aux_norm_i[1];
        end
        // level from the next status, so it rises with the flag
        irq_d = |(stat_d & mask_q);
    end

    // brake state and output registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            brk_q   <= PFBDZ_RUN;
            pwm_q   <= '0;
            aux_a_q <= 1'b0;
            aux_b_q <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            brk_q   <= brk_d;
            pwm_q   <= pwm_d;
            aux_a_q <= aux_a_d;
            aux_b_q <= aux_b_d;
            irq_q   <= irq_d;
        end
    end

    // outputs straight from flip-flops
    assign prdata_o    = prdata_q;
    assign pready_o    = pready_q;
    assign pslverr_o   = pslverr_q;
    assign pwm_o       = pwm_q;
    assign aux_out_a_o = aux_a_q;
    assign aux_out_b_o = aux_b_q;
    assign brake_o     = brk_q;
    assign irq_o       = irq_q;
endmodule

//--- sim/pfbdz_checker.sv
`timescale 1ns/10ps
// watches the top ports for bus, brake and dead-zone behaviour
module pfbdz_checker (
    // clock and reset
    input wire logic                   mclk_i,
    input wire logic                   rst_i,
    // apb slave side
    input wire logic                   psel_i,
    input wire logic                   penable_i,
    input wire logic                   pwrite_i,
    input wire pfbdz_pkg::pfbdz_addr_t paddr_i,
    input wire pfbdz_pkg::pfbdz_word_t pwdata_i,
    input wire logic                   pready_o,
    input wire logic                   pslverr_o,
    // pwm side
    input wire logic                   counter_restart_i,
    input wire logic [2:0]             pair_dz_en_i,
    input wire logic [5:0]             pwm_o,
    input wire logic                   aux_out_a_o,
    input wire logic                   aux_out_b_o,
    input wire logic                   brake_o,
    input wire logic                   irq_o
);
    import pfbdz_pkg::*;
    logic [7:0] lvl_q, lvl_d; // mirrored brake levels
    logic [1:0] en_q, en_d;   // mirrored input enables
    logic       wr_ctrl;      // completed control write
    logic [7:0] dz0_q, dz0_d; // mirrored pair-0 dead-zone length
    logic       wr_dz;        // completed dead-zone write
    assign wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h60;
    assign wr_dz = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h64;
    // next mirror values from completed control and dead-zone writes
    always_comb begin
        lvl_d = wr_ctrl ? pwdata_i[31:24] : lvl_q;
        en_d  = wr_ctrl ? pwdata_i[1:0] : en_q;
        dz0_d = wr_dz ? pwdata_i[7:0] : dz0_q;
    end
    // mirror registers
    always_ff @(posedge mclk_i) begin
        lvl_q <= rst_i ? 8'h00 : lvl_d;
        en_q  <= rst_i ? 2'h0 : en_d;
        dz0_q <= rst_i ? 8'h00 : dz0_d;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // bus steps
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i && pready_o
            && (pslverr_o == !(paddr_i inside {8'h60, 8'h64, 8'h70, 8'h74}));
    endsequence
    property p_rdy;
        s_setup |=> s_access ##1 !pready_o;
    endproperty
    a_rdy: assert property (p_rdy) else $error("bad bus answer");
    property p_lvl;
        brake_o && $past(brake_o) && $stable(lvl_q) |-> pwm_o == lvl_q[5:0];
    endproperty
    a_lvl: assert property (p_lvl) else $error("channel brake level");
    property p_aux;
        brake_o && $past(brake_o) && $stable(lvl_q) |-> {aux_out_b_o, aux_out_a_o} == lvl_q[7:6];
    endproperty
    a_aux: assert property (p_aux) else $error("aux brake level");
    property p_rise;
        $rose(brake_o) |-> pwm_o == lvl_q[5:0];
    endproperty
    a_rise: assert property (p_rise) else $error("levels late on entry");
    property p_en;
        $rose(brake_o) |-> en_q != 2'h0;
    endproperty
    a_en: assert property (p_en) else $error("brake with no enable");
    property p_hold;
        brake_o && !counter_restart_i |=> brake_o;
    endproperty
    a_hold: assert property (p_hold) else $error("brake left early");
    property p_rst;
        disable iff (1'b0) $fell(rst_i) |-> !brake_o && pwm_o == 6'h00 && !irq_o;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear");
    property p_dz;
        pair_dz_en_i[0] && $past(pair_dz_en_i[0], 3) && !brake_o && !$past(brake_o)
            && !$past(brake_o, 2) |-> !(pwm_o[0] && pwm_o[1])
            && (dz0_q == 8'h00 || !($rose(pwm_o[0]) || $rose(pwm_o[1]))
                || (!$past(pwm_o[0]) && !$past(pwm_o[1])));
    endproperty
    a_dz: assert property (p_dz) else $error("pair overlap");
endmodule

//--- sim/pfbdz_fault_pins.sv
`timescale 1ns/10ps
// fault pins seen from outside: pulled high, pulled low on request
module pfbdz_fault_pins (
    // one bit per pin to pull low
    input  wire logic [3:0] drop_i,
    // pins: irq0, irq1, comparator0, comparator1
    output logic [3:0]      pin_o
);
    // pins rest at the pull-up level between faults
    assign pin_o = ~drop_i;
endmodule

//--- sim/pwm_fault_brake_deadzone_tb_top.sv
`timescale 1ns/10ps
`include "pfbdz_cfg.svh"
// bus-level tests of the brake and dead-zone block
module pwm_fault_brake_deadzone_tb_top;
    import pfbdz_pkg::*;
    logic        mclk_i = 0, rst_i = 1;      // clock and reset
    logic        psel = 0, penable = 0;      // bus controls
    logic        pwrite = 0, restart = 0;    // direction, counter restart
    pfbdz_addr_t paddr = 0;                  // bus address
    pfbdz_word_t pwdata = 0, prdata, rd, w;  // bus data
    logic        pready, pslverr, err;       // bus answer
    logic        brake, irq, aux_a, aux_b;   // block outputs
    logic [5:0]  raw = 6'h2a, pwm;           // odd channels complement even
    logic [2:0]  dz_en = 0, tick = 0;        // dead-zone controls
    logic [3:0]  drop = 0, pins;             // fault pin requests
    logic [7:0]  lv;                         // brake levels under test
    int          num_errors = 0, n_tests = 0, n, len;
    pfbdz_addr_t offs[4] = '{`PFBDZ_OFF_CTRL, `PFBDZ_OFF_DZ, `PFBDZ_OFF_STAT, `PFBDZ_OFF_MASK};
    logic [7:0]  lvls[4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
    logic [3:0]  cfg[4] = '{4'h1, 4'h9, 4'h2, 4'h6};  // enable and source per case
    int          pin_of[4] = '{0, 3, 1, 2};          // pin feeding each case
    always #2 mclk_i = ~mclk_i;
    // one time unit every other cycle
    always @(posedge mclk_i) tick <= ~tick;
    pfbdz_fault_pins u_pins (.drop_i(drop), .pin_o(pins));
    pfbdz_top DUT (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .ext_irq_in_zero_i(pins[0]),
        .ext_irq_in_one_i(pins[1]), .comparator_out_zero_i(pins[2]),
        .comparator_out_one_i(pins[3]), .pwm_raw_i(raw), .pair_dz_en_i(dz_en),
        .pwm_clock_select_tick_i(tick), .counter_restart_i(restart), .aux_norm_i(2'h1),
        .pwm_o(pwm), .aux_out_a_o(aux_a), .aux_out_b_o(aux_b), .brake_o(brake), .irq_o(irq));
    // compare and count
    task automatic chk(input pfbdz_word_t got, input pfbdz_word_t exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, read data and error left in rd and err
    task automatic apb(input logic wr, input pfbdz_addr_t a, input pfbdz_word_t d);
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        // no bound on this wait: pready ends it, or the watchdog
        do @(posedge mclk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // wait a bounded time for the brake state
    task automatic wait_brk(input logic v);
        int k;
        k = 0;
        while (brake !== v && k < 40) begin @(posedge mclk_i); k++; end
        chk(32'(brake), 32'(v));
    endtask
    // one-cycle counter restart
    task automatic pulse();
        restart <= 1;
        @(posedge mclk_i);
        restart <= 0;
    endtask
    // verdict and end of run
    task automatic final_report();
        $display("errors %0d of %0d compares", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        final_report();
    end
    // test sequence
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 0;
        foreach (offs[i]) begin apb(0, offs[i], 0); chk(rd, 32'h0); end
        apb(0, 8'h68, 0); chk(rd | 32'(err), 32'h1);
        apb(1, `PFBDZ_OFF_CTRL, 32'hffff_ffff); apb(0, `PFBDZ_OFF_CTRL, 0);
        chk(rd, 32'hff00_000f);
        apb(1, `PFBDZ_OFF_DZ, 32'hffff_ffff); apb(0, `PFBDZ_OFF_DZ, 0);
        chk(rd, 32'h00ff_ffff);
        $display("test 1 done");
        // disabled input only raises its own flag
        apb(1, `PFBDZ_OFF_CTRL, 0); drop <= 4'h1;
        repeat (8) @(posedge mclk_i);
        drop <= 4'h0; chk(32'(brake), 32'h0);
        apb(0, `PFBDZ_OFF_STAT, 0); chk(rd, 32'h1);
        apb(1, `PFBDZ_OFF_STAT, 32'h7); apb(0, `PFBDZ_OFF_STAT, 0); chk(rd, 32'h0);
        $display("test 2 done");
        // every source and enable, four level patterns; last case masked
        for (int i = 0; i < 4; i++) begin
            lv = lvls[i];
            w = {lv, 20'h0, cfg[i]};
            apb(1, `PFBDZ_OFF_MASK, (i == 3) ? 32'h0 : 32'h7);
            apb(1, `PFBDZ_OFF_CTRL, w);
            drop[pin_of[i]] <= 1'b1;
            wait_brk(1);
            chk(32'(pwm), 32'(lv[5:0]));
            chk(32'({aux_b, aux_a}), 32'(lv[7:6]));
            drop <= 4'h0;
            chk(32'(irq), 32'(i != 3));
            apb(0, `PFBDZ_OFF_CTRL, 0); chk(rd, w | 32'h80);
            apb(0, `PFBDZ_OFF_STAT, 0); chk(rd, 32'h104 | (32'h1 << (i >> 1)));
            apb(1, `PFBDZ_OFF_CTRL, w); apb(0, `PFBDZ_OFF_CTRL, 0); chk(rd, w | 32'h80);
            pulse(); repeat (2) @(posedge mclk_i); chk(32'(brake), 32'h1);
            apb(1, `PFBDZ_OFF_CTRL, w | 32'h80); apb(0, `PFBDZ_OFF_CTRL, 0); chk(rd, w);
            chk(32'(brake), 32'h1);
            pulse(); wait_brk(0);
            chk(32'({aux_b, aux_a, pwm}), 32'h6a);
            apb(1, `PFBDZ_OFF_STAT, 32'h7); apb(0, `PFBDZ_OFF_STAT, 0); chk(rd, 32'h0);
            chk(32'(irq), 32'h0);
            $display("test 3.%0d done", i);
        end
        // dead zone per pair, lane and length from the unit ticks
        apb(1, `PFBDZ_OFF_CTRL, 0);
        for (int j = 0; j < 3; j++) begin
            len = 2 + j;
            apb(1, `PFBDZ_OFF_DZ, 32'(len) << (8 * j));
            dz_en <= 3'(1 << j);
            repeat (20) @(posedge mclk_i);
            raw <= 6'h2a ^ (6'h3 << (2 * j));
            n = 0;
            do begin @(posedge mclk_i); n++; end while (pwm[2 * j] !== 1'b1 && n < 100);
            chk(32'(n >= 2 * len && n <= 2 * len + 6), 32'h1);
            chk(32'(pwm[2 * j + 1]), 32'h0);
            raw <= 6'h2a;
            repeat (20) @(posedge mclk_i);
            $display("test 4.%0d done", j);
        end
        // reset in mid-run clears the dead-zone register again
        rst_i <= 1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 0;
        apb(0, `PFBDZ_OFF_DZ, 0); chk(rd, 32'h0);
        $display("test 5 done");
        final_report();
    end
endmodule

bind pfbdz_top pfbdz_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .counter_restart_i(counter_restart_i),
    .pair_dz_en_i(pair_dz_en_i), .pwm_o(pwm_o), .aux_out_a_o(aux_out_a_o),
    .aux_out_b_o(aux_out_b_o), .brake_o(brake_o), .irq_o(irq_o));
